// File: inc/scp_pkg.sv
// scp_pkg: constants and types for the serial control port host
package scp_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         CLK_NS          = 10;
  localparam int         SPI_QUARTER_NS  = 25;
  localparam int         I2C_QUARTER_NS  = 625;
  localparam logic [7:0] SPI_QUARTER_CYC = 8'((SPI_QUARTER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] I2C_QUARTER_CYC = 8'((I2C_QUARTER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] ABORT_QUARTERS  = 5'h10;
  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam logic [3:0]  I2C_ID_HI    = 4'hB;
  localparam logic        I2C_DIR_WR   = 1'h0;
  localparam logic        I2C_DIR_RD   = 1'h1;
  localparam logic        SPI_DIR_RD   = 1'h1;
  localparam logic [1:0]  LEN_STREAM   = 2'h3;
  localparam logic [15:0] SHORT_MAX    = 16'h0003;
  localparam int          INSTR_ADDR_W = 13;
  localparam logic [3:0]  SPI_LAST_BIT = 4'h7;
  localparam logic [3:0]  ACK_BIT      = 4'h8;
  localparam logic [15:0] INSTR_BITS   = 16'h0010;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SPI_WR     = 3'h0,
    OP_SPI_RD     = 3'h1,
    OP_I2C_PTR    = 3'h2,
    OP_I2C_WR     = 3'h3,
    OP_I2C_CUR_RD = 3'h4,
    OP_I2C_RD     = 3'h5
  } scp_op_t;

  typedef struct packed {
    scp_op_t     op;
    logic [15:0] addr;
    logic [15:0] count;
  } scp_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_LOAD  = 3'h3,
    ST_BIT   = 3'h2,
    ST_NEXT  = 3'h6,
    ST_STOP  = 3'h7,
    ST_STALL = 3'h5,
    ST_ABORT = 3'h4
  } scp_state_t;

  typedef enum logic [2:0] {
    STG_SLA_WR  = 3'h0,
    STG_ADDR_HI = 3'h1,
    STG_ADDR_LO = 3'h3,
    STG_SLA_RD  = 3'h2,
    STG_DATA    = 3'h6
  } scp_stg_t;
endpackage : scp_pkg

// File: verilog/scp_qtick.sv
// scp_qtick: quarter-bit tick divider for the serial clocks
module scp_qtick
  import scp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic i2c_i,
  output logic      tick_o
);
  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  logic [7:0] cnt_q;
  logic [7:0] last;

  assign last   = i2c_i ? I2C_QUARTER_CYC - 8'h01 : SPI_QUARTER_CYC - 8'h01;
  assign tick_o = run_i && (cnt_q == last);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (!run_i || cnt_q == last) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : scp_qtick

// File: verilog/scp_host.sv
// scp_host: host controller driving the serial control port over spi or i2c
module scp_host
  import scp_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CMD_VALID_I,
  input  wire scp_cmd_t   CMD_I,
  output logic            CMD_READY_O,
  input  wire logic [7:0] WR_DATA_I,
  input  wire logic       WR_VALID_I,
  output logic            WR_READY_O,
  output logic [7:0]      RD_DATA_O,
  output logic            RD_VALID_O,
  input  wire logic       UNIDIR_I,
  input  wire logic [2:0] I2C_ADDR_LO_I,
  input  wire logic       ABORT_I,
  output logic            BUSY_O,
  output logic            NACK_O,
  output logic            SPI_SCLK_O,
  output logic            SPI_CS_N_O,
  input  wire logic       SPI_SDIO_I,
  output logic            SPI_SDIO_O,
  output logic            SPI_SDIO_OE_O,
  input  wire logic       SERIAL_READBACK_PIN_I,
  input  wire logic       I2C_SCL_I,
  output logic            I2C_SCL_O,
  output logic            I2C_SCL_OE_O,
  input  wire logic       I2C_SDA_I,
  output logic            I2C_SDA_O,
  output logic            I2C_SDA_OE_O
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic scp_stg_t stg_after(scp_stg_t s, scp_op_t op);
    unique case (s)
      STG_SLA_WR:  stg_after = STG_ADDR_HI;
      STG_ADDR_HI: stg_after = STG_ADDR_LO;
      STG_ADDR_LO: stg_after = (op == OP_I2C_RD) ? STG_SLA_RD : STG_DATA;
      default:     stg_after = STG_DATA;
    endcase
  endfunction : stg_after

  function automatic logic [15:0] spi_instr(logic rd, logic [15:0] n, logic [15:0] a);
    logic [1:0] len;
    len       = (n > SHORT_MAX) ? LEN_STREAM : n[1:0] - 2'h1;
    spi_instr = {rd ? SPI_DIR_RD : ~SPI_DIR_RD, len, a[INSTR_ADDR_W-1:0]};
  endfunction : spi_instr

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  scp_state_t  st_q;
  scp_stg_t    stg_q;
  scp_op_t     op_q;
  logic [15:0] hdr_q, cnt_q, edge_q, cnt_in;
  logic [7:0]  sh_q, rd_data_q;
  logic [3:0]  bit_q, s1_q, s2_q;
  logic [4:0]  ab_q;
  logic [1:0]  ph_q;
  logic        i2c_q, rd_q, stream_q, ack_q, nack_q, rd_valid_q;
  logic        sclk_q, cs_n_q, sdio_q, sdio_oe_q, sda_q, scl_q;
  logic        tick, adv, acc, need_wr, ld_ok, ld_stall, ld_abort;
  logic        data_ph, host_tx, in_bit, bit_end, done, restart;
  logic        sdio_s, rb_s, sda_s, scl_s, i2c_in, rd_in;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
    end else begin
      s1_q <= {I2C_SCL_I, I2C_SDA_I, SERIAL_READBACK_PIN_I, SPI_SDIO_I};
      s2_q <= s1_q;
    end
  end
  assign {scl_s, sda_s, rb_s, sdio_s} = s2_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  scp_qtick u_tick (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .run_i  (st_q inside {ST_START, ST_BIT, ST_STOP, ST_ABORT}),
    .i2c_i  (i2c_q),
    .tick_o (tick)
  );

  assign adv      = tick && !(i2c_q && ph_q == 2'h2 && !scl_s);
  assign acc      = (st_q == ST_IDLE) && CMD_VALID_I;
  assign data_ph  = (stg_q == STG_DATA);
  assign host_tx  = !(data_ph && rd_q);
  assign need_wr  = data_ph && !rd_q;
  assign ld_ok    = (st_q == ST_LOAD) && !(need_wr && !WR_VALID_I);
  assign ld_stall = (st_q == ST_LOAD) && need_wr && !WR_VALID_I && !i2c_q && !stream_q;
  assign ld_abort = (st_q == ST_LOAD) && need_wr && !WR_VALID_I && ABORT_I && (i2c_q || stream_q);
  assign in_bit   = i2c_q ? sda_s : (UNIDIR_I ? rb_s : sdio_s);
  assign bit_end  = (st_q == ST_BIT) && adv && ph_q == 2'h3 && bit_q == (i2c_q ? ACK_BIT : SPI_LAST_BIT);
  assign done     = (stg_q == STG_ADDR_LO && op_q == OP_I2C_PTR)
                  || (data_ph && cnt_q == 16'h0001)
                  || (i2c_q && host_tx && ack_q);
  assign restart  = (stg_q == STG_ADDR_LO) && (op_q == OP_I2C_RD);
  assign cnt_in   = (CMD_I.count == 16'h0000) ? 16'h0001 : CMD_I.count;
  assign i2c_in   = (CMD_I.op >= OP_I2C_PTR);
  assign rd_in    = CMD_I.op inside {OP_SPI_RD, OP_I2C_CUR_RD, OP_I2C_RD};

  // ---------------------------------------------------------------
  // control fsm
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE:  if (acc) st_q <= ST_START;
        ST_START: if (adv && ph_q == 2'h3) st_q <= ST_LOAD;
        ST_LOAD: begin
          if (ld_ok) st_q <= ST_BIT;
          else if (ld_stall) st_q <= ST_STALL;
          else if (ld_abort) st_q <= ST_STOP;
        end
        ST_BIT:   if (bit_end) st_q <= ST_NEXT;
        ST_NEXT: begin
          if (done) st_q <= ST_STOP;
          else if (restart) st_q <= ST_START;
          else st_q <= ST_LOAD;
        end
        ST_STALL: begin
          if (ABORT_I) st_q <= ST_ABORT;
          else if (WR_VALID_I) st_q <= ST_START;
        end
        ST_ABORT: if (adv && ab_q == ABORT_QUARTERS - 5'h01) st_q <= ST_STOP;
        ST_STOP:  if (adv && ph_q == 2'h3) st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ph_q  <= 2'h0;
      bit_q <= 4'h0;
      ab_q  <= 5'h00;
    end else begin
      if (adv && st_q inside {ST_START, ST_BIT, ST_STOP}) ph_q <= ph_q + 2'h1;
      if (st_q == ST_LOAD) bit_q <= 4'h0;
      else if (st_q == ST_BIT && adv && ph_q == 2'h3) bit_q <= bit_q + 4'h1;
      if (st_q != ST_ABORT) ab_q <= 5'h00;
      else if (adv) ab_q <= ab_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // byte sequencing and shifter
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      op_q     <= OP_SPI_WR;
      stg_q    <= STG_ADDR_HI;
      hdr_q    <= 16'h0000;
      cnt_q    <= 16'h0000;
      i2c_q    <= 1'h0;
      rd_q     <= 1'h0;
      stream_q <= 1'h0;
      sh_q     <= 8'h00;
      ack_q    <= 1'h0;
    end else if (acc) begin
      op_q     <= CMD_I.op;
      i2c_q    <= i2c_in;
      rd_q     <= rd_in;
      cnt_q    <= cnt_in;
      stream_q <= !i2c_in && cnt_in > SHORT_MAX;
      hdr_q    <= i2c_in ? CMD_I.addr : spi_instr(rd_in, cnt_in, CMD_I.addr);
      stg_q    <= !i2c_in ? STG_ADDR_HI : (CMD_I.op == OP_I2C_CUR_RD) ? STG_SLA_RD : STG_SLA_WR;
    end else if (ld_ok) begin
      ack_q <= 1'h0;
      unique case (stg_q)
        STG_SLA_WR:  sh_q <= {I2C_ID_HI, I2C_ADDR_LO_I, I2C_DIR_WR};
        STG_SLA_RD:  sh_q <= {I2C_ID_HI, I2C_ADDR_LO_I, I2C_DIR_RD};
        STG_ADDR_HI: sh_q <= hdr_q[15:8];
        STG_ADDR_LO: sh_q <= hdr_q[7:0];
        default:     sh_q <= rd_q ? 8'hFF : WR_DATA_I;
      endcase
    end else if (st_q == ST_BIT && adv && ph_q == 2'h2) begin
      if (bit_q == ACK_BIT) ack_q <= in_bit;
      else sh_q <= {sh_q[6:0], in_bit};
    end else if (st_q == ST_NEXT) begin
      if (data_ph) cnt_q <= cnt_q - 16'h0001;
      if (!done) stg_q <= stg_after(stg_q, op_q);
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_q    <= 1'h0;
      cs_n_q    <= 1'h1;
      sdio_q    <= 1'h0;
      sdio_oe_q <= 1'h0;
      sda_q     <= 1'h1;
      scl_q     <= 1'h1;
    end else if (ld_stall) begin
      cs_n_q    <= 1'h1;
      sdio_oe_q <= 1'h0;
    end else if (st_q == ST_ABORT && adv && ab_q == 5'h00) begin
      cs_n_q <= 1'h0;
    end else if (adv) begin
      unique case (st_q)
        ST_START: begin
          if (!i2c_q) begin
            if (ph_q == 2'h0) cs_n_q <= 1'h0;
          end else begin
            unique case (ph_q)
              2'h0: sda_q <= 1'h1;
              2'h1: scl_q <= 1'h1;
              2'h2: sda_q <= 1'h0;
              2'h3: scl_q <= 1'h0;
            endcase
          end
        end
        ST_BIT: begin
          unique case (ph_q)
            2'h0: begin
              sdio_q    <= sh_q[7];
              sdio_oe_q <= !i2c_q && host_tx;
              if (bit_q == ACK_BIT) sda_q <= host_tx ? 1'h1 : (cnt_q == 16'h0001);
              else sda_q <= host_tx ? sh_q[7] : 1'h1;
            end
            2'h1: begin
              sclk_q <= !i2c_q;
              scl_q  <= 1'h1;
            end
            2'h2: begin
              sclk_q <= sclk_q;
            end
            2'h3: begin
              sclk_q <= 1'h0;
              scl_q  <= !i2c_q;
            end
          endcase
        end
        ST_STOP: begin
          if (!i2c_q) begin
            if (ph_q == 2'h1) begin
              cs_n_q    <= 1'h1;
              sdio_oe_q <= 1'h0;
            end
          end else begin
            unique case (ph_q)
              2'h0: sda_q <= 1'h0;
              2'h1: scl_q <= 1'h1;
              2'h2: sda_q <= 1'h1;
              2'h3: scl_q <= 1'h1;
            endcase
          end
        end
        default: sclk_q <= 1'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // user side
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'h0;
      nack_q     <= 1'h0;
      edge_q     <= 16'h0000;
    end else begin
      rd_valid_q <= (st_q == ST_NEXT) && data_ph && rd_q;
      if ((st_q == ST_NEXT) && data_ph && rd_q) rd_data_q <= sh_q;
      if ((st_q == ST_NEXT) && i2c_q && host_tx && ack_q) nack_q <= 1'h1;
      else if (acc) nack_q <= 1'h0;
      if (acc) edge_q <= 16'h0000;
      else if (st_q == ST_BIT && adv && ph_q == 2'h1 && !i2c_q) edge_q <= edge_q + 16'h0001;
    end
  end

  assign CMD_READY_O   = (st_q == ST_IDLE);
  assign WR_READY_O    = ld_ok && need_wr;
  assign RD_DATA_O     = rd_data_q;
  assign RD_VALID_O    = rd_valid_q;
  assign BUSY_O        = (st_q != ST_IDLE);
  assign NACK_O        = nack_q;
  assign SPI_SCLK_O    = sclk_q;
  assign SPI_CS_N_O    = cs_n_q;
  assign SPI_SDIO_O    = sdio_q;
  assign SPI_SDIO_OE_O = sdio_oe_q;
  assign I2C_SCL_O     = 1'h0;
  assign I2C_SCL_OE_O  = !scl_q;
  assign I2C_SDA_O     = 1'h0;
  assign I2C_SDA_OE_O  = !sda_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_cs_fall;
    $fell(cs_n_q) |-> $past(st_q) inside {ST_START, ST_ABORT};
  endproperty
  a_cs_fall: assert property (p_cs_fall) else $error("cs fell outside start or abort");

  property p_instr_len;
    (!i2c_q && $rose(stg_q == STG_DATA)) |-> edge_q == INSTR_BITS;
  endproperty
  a_instr_len: assert property (p_instr_len) else $error("instruction not sixteen edges");

  property p_byte_edge;
    $rose(cs_n_q) |-> edge_q[2:0] == 3'h0;
  endproperty
  a_byte_edge: assert property (p_byte_edge) else $error("cs rose off a byte boundary");

  property p_stall_short;
    (st_q == ST_STALL) |-> (!stream_q && cs_n_q && !sclk_q);
  endproperty
  a_stall_short: assert property (p_stall_short) else $error("bad stall");

  property p_end_cycle;
    (st_q == ST_NEXT && done && !i2c_q) |-> ##[1:12] $rose(cs_n_q);
  endproperty
  a_end_cycle: assert property (p_end_cycle) else $error("cs did not rise after last byte");

  property p_abort_quiet;
    (st_q == ST_ABORT) |-> !sclk_q ##1 ((st_q == ST_ABORT) || (st_q == ST_STOP && !sclk_q));
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("clock ran during abort");

  property p_sample_high;
    (st_q == ST_BIT && adv && ph_q == 2'h2 && !i2c_q) |-> sclk_q && $past(sclk_q, 4) == 1'h0;
  endproperty
  a_sample_high: assert property (p_sample_high) else $error("sample not after rising edge");

  property p_read_release;
    (!i2c_q && rd_q && data_ph && st_q == ST_BIT && ph_q != 2'h0) |-> !sdio_oe_q;
  endproperty
  a_read_release: assert property (p_read_release) else $error("host drove data pin in read");

  property p_cs_release;
    cs_n_q |-> !sdio_oe_q;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("data pin driven with cs high");

  property p_sla;
    (ld_ok && stg_q inside {STG_SLA_WR, STG_SLA_RD}) |=> sh_q[7:1] == {I2C_ID_HI, $past(I2C_ADDR_LO_I)};
  endproperty
  a_sla: assert property (p_sla) else $error("wrong slave address");

  property p_addr_hi;
    (ld_ok && i2c_q && stg_q == STG_ADDR_HI) |=> sh_q == hdr_q[15:8];
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address high byte not first");

  property p_nack_last;
    (i2c_q && rd_q && data_ph && st_q == ST_BIT && bit_q == ACK_BIT && ph_q == 2'h2)
      |-> sda_q == (cnt_q == 16'h0001);
  endproperty
  a_nack_last: assert property (p_nack_last) else $error("ack on read data wrong");

  property p_sda_stable;
    (i2c_q && scl_q && $past(scl_q) && $changed(sda_q)) |-> $past(st_q) inside {ST_START, ST_STOP};
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved while scl high");

  property p_restart;
    (st_q == ST_NEXT && restart && !done) |=> (st_q == ST_START && stg_q == STG_SLA_RD);
  endproperty
  a_restart: assert property (p_restart) else $error("no repeated start");
endmodule : scp_host

// File: verif/scp_dev_model.sv
// scp_dev_model: behavioural spi target with shadow and active registers
module scp_dev_model (
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic sdio_i,
  output logic      sdio_o,
  output logic      sdo_o
);
  timeunit 1ns;
  timeprecision 1ns;
  bit [7:0]  shd [8192];
  bit [7:0]  act [8192];
  bit [15:0] ins;
  bit [12:0] adr;
  bit [7:0]  sh;
  bit        bv;
  bit        edg;
  bit        jnk;
  int        cnt;
  wire       rd  = ins[15];
  wire       str = (cnt > 16) && (ins[14:13] == 2'h3);
  wire       drv = !cs_n_i && rd && (cnt >= 16);
  wire       uni = shd[0][7];
  // ---------------------------------------------------------------
  // shift in on rising sclk, out on falling
  // ---------------------------------------------------------------
  always @(posedge sclk_i) if (!cs_n_i) begin
    edg = 1'b1;
    cnt++;
    if (cnt <= 16) begin
      ins = {ins[14:0], sdio_i};
      adr = ins[12:0];
    end else if (!rd) begin
      sh = {sh[6:0], sdio_i};
      if (cnt % 8 == 0) begin
        shd[adr] = sh;
        if (adr == 13'h0232 && sh[0]) begin
          act = shd;
          act[13'h0232][0] = 1'b0;
          shd[13'h0232][0] = 1'b0;
        end
        adr--;
      end
    end else if (cnt % 8 == 0) begin
      adr--;
    end
  end
  always @(negedge sclk_i) begin
    jnk = ~jnk;
    if (drv) bv = act[adr][7 - (cnt - 16) % 8];
  end
  assign sdio_o = (drv && !uni) ? bv : jnk;
  assign sdo_o  = (drv && uni) ? bv : jnk;
  // ---------------------------------------------------------------
  // chip select: stall, end, abort, off-boundary reset
  // ---------------------------------------------------------------
  always @(negedge cs_n_i) edg = 1'b0;
  always @(posedge cs_n_i) begin
    if (cnt % 8 != 0 || str || cnt == 16 + 8 * (int'(ins[14:13]) + 1) || (!edg && cnt > 0)) begin
      cnt = 0;
    end
  end
endmodule : scp_dev_model

// File: verif/scp_host_bench.sv
// scp_host_bench: self-checking bench for the serial control port host
module scp_host_bench
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       CLK_I = 0;
  logic       RST_I = 1;
  logic       CMD_VALID_I = 0;
  scp_cmd_t   CMD_I = '0;
  logic [7:0] WR_DATA_I = '0;
  logic       WR_VALID_I = 0;
  logic       UNIDIR_I = 0;
  logic       ABORT_I = 0;
  logic [2:0] I2C_ADDR_LO_I = '0;
  wire        CMD_READY_O, WR_READY_O, RD_VALID_O, BUSY_O, NACK_O, SPI_SCLK_O, SPI_CS_N_O;
  wire        SPI_SDIO_O, SPI_SDIO_OE_O, I2C_SCL_O, I2C_SCL_OE_O, I2C_SDA_O, I2C_SDA_OE_O;
  wire        dev_sdio, dev_sdo;
  wire [7:0]  RD_DATA_O;
  wire        sdio = SPI_SDIO_OE_O ? SPI_SDIO_O : dev_sdio;
  int         miscompares, n_tests;
  logic [7:0] expq [$];
  bit [7:0]   shd [8192];
  bit [7:0]   act [8192];
  always #5 CLK_I = ~CLK_I;
  scp_host uut (.CLK_I(CLK_I), .RST_I(RST_I), .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I),
    .CMD_READY_O(CMD_READY_O), .WR_DATA_I(WR_DATA_I), .WR_VALID_I(WR_VALID_I), .WR_READY_O(WR_READY_O),
    .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .UNIDIR_I(UNIDIR_I), .I2C_ADDR_LO_I(I2C_ADDR_LO_I),
    .ABORT_I(ABORT_I), .BUSY_O(BUSY_O), .NACK_O(NACK_O), .SPI_SCLK_O(SPI_SCLK_O), .SPI_CS_N_O(SPI_CS_N_O),
    .SPI_SDIO_I(sdio), .SPI_SDIO_O(SPI_SDIO_O), .SPI_SDIO_OE_O(SPI_SDIO_OE_O),
    .SERIAL_READBACK_PIN_I(dev_sdo), .I2C_SCL_I(~I2C_SCL_OE_O), .I2C_SCL_O(I2C_SCL_O),
    .I2C_SCL_OE_O(I2C_SCL_OE_O), .I2C_SDA_I(~I2C_SDA_OE_O), .I2C_SDA_O(I2C_SDA_O), .I2C_SDA_OE_O(I2C_SDA_OE_O));
  scp_dev_model dev (.sclk_i(SPI_SCLK_O), .cs_n_i(SPI_CS_N_O), .sdio_i(sdio), .sdio_o(dev_sdio), .sdo_o(dev_sdo));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_idle;
    @(negedge CLK_I);
    for (int k = 0; k < 20000 && BUSY_O !== 1'b0; k++) @(negedge CLK_I);
    if (BUSY_O !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_idle
  task automatic cmd(input scp_op_t op, input logic [15:0] a, input logic [15:0] n);
    @(posedge CLK_I);
    CMD_VALID_I <= 1'b1;
    CMD_I       <= '{op, a, n};
    do @(negedge CLK_I); while (CMD_READY_O !== 1'b1);
    @(posedge CLK_I);
    CMD_VALID_I <= 1'b0;
  endtask : cmd
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge CLK_I);
    @(posedge CLK_I);
    WR_VALID_I <= 1'b1;
    WR_DATA_I  <= b;
    do @(negedge CLK_I); while (WR_READY_O !== 1'b1);
    @(posedge CLK_I);
    WR_VALID_I <= 1'b0;
  endtask : put
  task automatic spi_wr(input logic [15:0] a, input int n, input int gap, input int v);
    logic [7:0] b;
    cmd(OP_SPI_WR, a, 16'(n));
    for (int i = 0; i < n; i++) begin
      b = (v < 0) ? 8'($urandom) : 8'(v);
      put(b, i ? gap : 0);
      shd[a - i] = b;
      if (a - i == 16'h0232 && b[0]) begin
        act = shd;
        act[16'h0232][0] = 1'b0;
        shd[16'h0232][0] = 1'b0;
      end
    end
    wait_idle();
  endtask : spi_wr
  task automatic spi_rd(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) expq.push_back(act[a - i]);
    cmd(OP_SPI_RD, a, 16'(n));
    wait_idle();
    chk(16'(expq.size()), 16'h0000);
  endtask : spi_rd
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // read monitor, watchdog, sequence
  // ---------------------------------------------------------------
  always @(negedge CLK_I) if (RD_VALID_O === 1'b1) begin
    chk(RD_DATA_O, expq.size() ? expq.pop_front() : 16'hFFFF);
  end
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  initial begin
    int a;
    a = $urandom(50329);
    repeat (3) @(posedge CLK_I);
    RST_I         <= 1'b0;
    I2C_ADDR_LO_I <= 3'($urandom);
    @(negedge CLK_I);
    chk({CMD_READY_O, BUSY_O, SPI_CS_N_O, SPI_SCLK_O, SPI_SDIO_OE_O}, 16'h0014);
    a = 16'h0100 + $urandom % 16'h0080;
    spi_wr(16'(a), 3, 150, -1);
    spi_rd(16'(a), 3);
    spi_wr(16'h0232, 1, 0, 1);
    spi_rd(16'(a), 3);
    spi_rd(16'h0232, 1);
    spi_wr(16'h0320, 5, 0, -1);
    spi_wr(16'h0232, 1, 0, 1);
    spi_rd(16'h0320, 5);
    spi_rd(16'h031F, 2);
    spi_wr(16'h0000, 1, 0, 16'h0081);
    @(posedge CLK_I);
    UNIDIR_I <= 1'b1;
    spi_rd(16'(a), 3);
    spi_wr(16'h0000, 1, 0, 0);
    @(posedge CLK_I);
    UNIDIR_I <= 1'b0;
    spi_rd(16'(a - 1), 1);
    cmd(OP_SPI_WR, 16'h0410, 16'h0002);
    put(8'h5A, 0);
    shd[16'h0410] = 8'h5A;
    ABORT_I <= 1'b1;
    wait_idle();
    @(posedge CLK_I);
    ABORT_I <= 1'b0;
    spi_wr(16'h0232, 1, 0, 1);
    spi_rd(16'h0410, 2);
    cmd(OP_I2C_PTR, 16'h0010, 16'h0000);
    wait_idle();
    chk({NACK_O, I2C_SCL_OE_O, I2C_SDA_OE_O, SPI_CS_N_O}, 16'h0009);
    spi_rd(16'(a), 1);
    chk(NACK_O, 16'h0000);
    wrap_up();
  end
endmodule : scp_host_bench
